// ---- core/rfs_supervisor.sv ----
// regulator fault supervisor: input and output voltage faults, latch or
// retry response, prebias start-up and current-sense setup
// assumes measurements and configuration come from logic on mclk; the
// enable pin is asynchronous
`timescale 1ns/1ns
`default_nettype none
`include "rfs_regs.svh"
module rfs_supervisor #(
  parameter int RISE_CYCLES = `RFS_RISE_CYCLES,
  parameter int TON_DELAY_CYCLES = `RFS_TON_DELAY_CYCLES,
  parameter int RETRY_UNIT_CYCLES = `RFS_RETRY_UNIT_CYCLES
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // enable pin
  input wire logic enable_pin,
  // measurements from the converters
  input wire logic [15:0] vin_meas,
  input wire logic [15:0] output_sense_input,
  // programmed limits
  input wire rfs_pkg::rfs_limits_t limits,
  // command port of the serial interface
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [7:0] cfg_code,
  input wire logic [15:0] cfg_wdata,
  output logic [15:0] cfg_rdata,
  // current sense setup in and the held selection out
  input wire logic [2:0] current_sense_setup,
  output logic isense_slope_up,
  output logic [1:0] isense_range,
  // towards the modulator
  output logic regulate_en,
  output logic [15:0] duty_init,
  output logic [15:0] vout_ref,
  // status
  output logic output_good_flag,
  output rfs_pkg::rfs_fault_t fault_cause,
  output rfs_pkg::rfs_state_t seq_state
);

  generate
    if (TON_DELAY_CYCLES < 1 || RETRY_UNIT_CYCLES < 1) begin : g_bad_timing
      $error("rfs_supervisor: delay counts must be at least 1");
    end
  endgenerate

  rfs_pkg::rfs_core_t r;
  rfs_pkg::rfs_core_t next_r;
  rfs_pkg::rfs_fault_t live;
  logic en_s;
  logic en_rise;
  logic en_fall;
  logic ramp_sw;
  logic ramp_done;
  logic [15:0] ramp_ref;
  logic ramp_stop;

  // duty as prebias over input, 0.16 fraction, saturated
  function automatic logic [15:0] duty_of(input logic [15:0] v, input logic [15:0] vi);
    logic [31:0] q;
    q = 32'h0;
    if (vi == 16'h0 || v >= vi) begin
      return 16'hffff;
    end
    q = {v, 16'h0} / {16'h0, vi};
    return q[15:0];
  endfunction

  // retry wait in cycles from a response byte delay code
  function automatic logic [31:0] retry_wait(input logic [7:0] resp);
    logic [31:0] code;
    code = {29'h0, resp[`RFS_RESP_DLY_MSB:`RFS_RESP_DLY_LSB]} + 32'h1;
    return code * 32'(RETRY_UNIT_CYCLES);
  endfunction

  // enable pin crosses into mclk before its edges are looked at
  rfs_sync u_en_sync (
    .mclk(mclk),
    .rst(rst),
    .din(enable_pin),
    .dout(en_s)
  );

  assign en_rise = en_s & ~r.en_prev;
  assign en_fall = ~en_s & r.en_prev;
  // the reference must hold at target while on; clearing it there would
  // pull the output down and trip the undervoltage check
  assign ramp_stop = !(r.state inside {rfs_pkg::st_ramp, rfs_pkg::st_on}) && !r.ramp_go;

  rfs_ramp #(
    .RISE_CYCLES(RISE_CYCLES)
  ) u_ramp (
    .mclk(mclk),
    .rst(rst),
    .go(r.ramp_go),
    .down(r.ramp_down),
    .stop(ramp_stop),
    .start(r.prebias),
    .target(limits.vout_target),
    .ref_v(ramp_ref),
    .switching(ramp_sw),
    .done(ramp_done)
  );

  // live comparisons against the programmed limits
  always_comb begin
    live.vin_uv = vin_meas < limits.vin_uv_fault;
    live.vin_ov = vin_meas > limits.vin_ov_fault;
    live.vout_ov = output_sense_input > limits.vout_ov_fault;
    // masked while ramping; the host keeps this limit below good-on
    live.vout_uv = (r.state == rfs_pkg::st_on) && r.pg &&
                   (output_sense_input < limits.vout_uv_fault);
  end

  // sequencer, fault responses and the command registers
  always_comb begin
    next_r = r;
    next_r.en_prev = en_s;
    next_r.ramp_go = 1'b0;

    // current sense setup; the unused range code keeps the last choice
    next_r.sense_up = current_sense_setup[`RFS_ISS_SLOPE_BIT];
    if (current_sense_setup[`RFS_ISS_RANGE_MSB:`RFS_ISS_RANGE_LSB] != 2'h3) begin
      next_r.sense_range =
        current_sense_setup[`RFS_ISS_RANGE_MSB:`RFS_ISS_RANGE_LSB];
    end

    case (r.state)
      rfs_pkg::st_off: begin
        next_r.regulate = 1'b0;
        next_r.pg = 1'b0;
        if (en_rise) begin
          next_r.state = rfs_pkg::st_delay;
          next_r.cnt = 32'h0;
          next_r.cause = '0;
        end
      end
      rfs_pkg::st_delay, rfs_pkg::st_ramp, rfs_pkg::st_on: begin
        if (r.pend) begin
          // second step of a fault: output-good already low, now stop
          next_r.pend = 1'b0;
          next_r.regulate = 1'b0;
          next_r.cnt = 32'h0;
          next_r.dis_seen = 1'b0;
          if ((r.cause.vin_uv && !r.vin_uv_resp[`RFS_RESP_RETRY_BIT]) ||
              (r.cause.vin_ov && !r.vin_ov_resp[`RFS_RESP_RETRY_BIT]) ||
              (r.cause.vout_ov && !r.vout_ov_resp[`RFS_RESP_RETRY_BIT]) ||
              (r.cause.vout_uv && !r.vout_uv_resp[`RFS_RESP_RETRY_BIT])) begin
            next_r.state = rfs_pkg::st_latch;
          end else begin
            next_r.state = rfs_pkg::st_retry;
          end
        end else if (en_fall) begin
          next_r.state = rfs_pkg::st_off;
          next_r.regulate = 1'b0;
          next_r.pg = 1'b0;
        end else if (live != '0) begin
          next_r.pg = 1'b0;
          next_r.cause = live;
          next_r.pend = 1'b1;
        end else if (r.state == rfs_pkg::st_delay) begin
          next_r.cnt = r.cnt + 32'h1;
          if (next_r.cnt >= 32'(TON_DELAY_CYCLES)) begin
            next_r.prebias = output_sense_input;
            if (output_sense_input > r.vout_ov_warn) begin
              next_r.state = rfs_pkg::st_hold;
              next_r.dis_seen = 1'b0;
            end else begin
              next_r.duty = duty_of(output_sense_input, vin_meas);
              next_r.ramp_down = output_sense_input > limits.vout_target;
              next_r.ramp_go = 1'b1;
              next_r.state = rfs_pkg::st_ramp;
            end
          end
        end else if (r.state == rfs_pkg::st_ramp) begin
          next_r.regulate = ramp_sw;
          if (ramp_done) begin
            next_r.state = rfs_pkg::st_on;
          end
        end else begin
          next_r.regulate = 1'b1;
          if (output_sense_input >= limits.pg_on) begin
            next_r.pg = 1'b1;
          end
        end
      end
      rfs_pkg::st_retry: begin
        next_r.regulate = 1'b0;
        if (en_fall) begin
          next_r.state = rfs_pkg::st_off;
        end else if (r.cnt < retry_wait(r.cause.vin_uv ? r.vin_uv_resp :
                                        r.cause.vin_ov ? r.vin_ov_resp :
                                        r.cause.vout_ov ? r.vout_ov_resp :
                                        r.vout_uv_resp)) begin
          next_r.cnt = r.cnt + 32'h1;
        end else if ((!r.cause.vin_uv || vin_meas > limits.vin_uv_warn) &&
                     (!r.cause.vin_ov || vin_meas < limits.vin_ov_warn) &&
                     (!r.cause.vout_ov || output_sense_input < r.vout_ov_warn)) begin
          // undervoltage on the output restarts through a soft start
          next_r.state = rfs_pkg::st_delay;
          next_r.cnt = 32'h0;
          next_r.cause = '0;
        end
      end
      rfs_pkg::st_latch, rfs_pkg::st_hold: begin
        next_r.regulate = 1'b0;
        next_r.pg = 1'b0;
        if (en_fall) begin
          next_r.dis_seen = 1'b1;
        end
        if (en_rise && r.dis_seen) begin
          next_r.dis_seen = 1'b0;
          // restart only once the condition that stopped us has gone
          if (r.state == rfs_pkg::st_latch ? ((r.cause.vin_uv && live.vin_uv) ||
                                              (r.cause.vin_ov && live.vin_ov) ||
                                              (r.cause.vout_ov && live.vout_ov)) == 1'b0
                                           : output_sense_input <= r.vout_ov_warn) begin
            next_r.state = rfs_pkg::st_delay;
            next_r.cnt = 32'h0;
            next_r.cause = '0;
          end
        end
      end
      default: begin
        next_r.state = rfs_pkg::st_off;
        next_r.regulate = 1'b0;
        next_r.pg = 1'b0;
      end
    endcase

    // an input below the fault limit never lets the stage switch
    if (live.vin_uv) begin
      next_r.regulate = 1'b0;
    end

    // command writes and reads; unknown codes read zero
    if (cfg_wr) begin
      case (cfg_code)
        `RFS_OFS_VOUT_OV_RESP: next_r.vout_ov_resp = cfg_wdata[7:0];
        `RFS_OFS_VOUT_OV_WARN: next_r.vout_ov_warn = cfg_wdata;
        `RFS_OFS_VOUT_UV_RESP: next_r.vout_uv_resp = cfg_wdata[7:0];
        `RFS_OFS_VIN_OV_RESP: next_r.vin_ov_resp = cfg_wdata[7:0];
        `RFS_OFS_VIN_UV_RESP: next_r.vin_uv_resp = cfg_wdata[7:0];
        default: ;
      endcase
    end
    if (cfg_rd) begin
      case (cfg_code)
        `RFS_OFS_VOUT_OV_RESP: next_r.rdata = {8'h00, r.vout_ov_resp};
        `RFS_OFS_VOUT_OV_WARN: next_r.rdata = r.vout_ov_warn;
        `RFS_OFS_VOUT_UV_RESP: next_r.rdata = {8'h00, r.vout_uv_resp};
        `RFS_OFS_VIN_OV_RESP: next_r.rdata = {8'h00, r.vin_ov_resp};
        `RFS_OFS_VIN_UV_RESP: next_r.rdata = {8'h00, r.vin_uv_resp};
        default: next_r.rdata = 16'h0000;
      endcase
    end
  end

  // response registers default to latch, warning limit to full scale
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      r <= '0;
      r.state <= rfs_pkg::st_off;
      r.vout_ov_resp <= `RFS_RESP_RESET;
      r.vout_ov_warn <= `RFS_WARN_RESET;
      r.vout_uv_resp <= `RFS_RESP_RESET;
      r.vin_ov_resp <= `RFS_RESP_RESET;
      r.vin_uv_resp <= `RFS_RESP_RESET;
      r.sense_range <= `RFS_ISR_15MV;
    end else begin
      r <= next_r;
    end
  end

  // outputs straight from flops (the reference from the ramp's flops)
  assign cfg_rdata = r.rdata;
  assign isense_slope_up = r.sense_up;
  assign isense_range = r.sense_range;
  assign regulate_en = r.regulate;
  assign duty_init = r.duty;
  assign vout_ref = ramp_ref;
  assign output_good_flag = r.pg;
  assign fault_cause = r.cause;
  assign seq_state = r.state;

endmodule // rfs_supervisor
`default_nettype wire

// ---- pkg/rfs_regs.svh ----
// command codes, field positions, reset values and timing counts of the fault supervisor
// assumes an includer that compiles it once per unit; definitions only
`ifndef RFS_REGS_SVH
`define RFS_REGS_SVH

// command codes of the response and warning registers
`define RFS_OFS_VOUT_OV_RESP 8'h41
`define RFS_OFS_VOUT_OV_WARN 8'h42
`define RFS_OFS_VOUT_UV_RESP 8'h45
`define RFS_OFS_VIN_OV_RESP 8'h56
`define RFS_OFS_VIN_UV_RESP 8'h5a

// response byte layout: retry select and retry delay code
`define RFS_RESP_RETRY_BIT 6
`define RFS_RESP_DLY_MSB 2
`define RFS_RESP_DLY_LSB 0
`define RFS_RESP_RESET 8'h00
`define RFS_WARN_RESET 16'hffff

// current sense setup: slope bit and range field
`define RFS_ISS_SLOPE_BIT 0
`define RFS_ISS_RANGE_MSB 2
`define RFS_ISS_RANGE_LSB 1
`define RFS_ISR_15MV 2'h0
`define RFS_ISR_30MV 2'h1
`define RFS_ISR_60MV 2'h2

// timing at a 25 MHz core clock
`define RFS_CLK_MHZ 25
`define RFS_TON_RISE_US 5000
`define RFS_TON_DELAY_US 0
`define RFS_RETRY_UNIT_US 1000
`define RFS_RISE_CYCLES (`RFS_TON_RISE_US * `RFS_CLK_MHZ)
`define RFS_TON_DELAY_CYCLES \
  ((`RFS_TON_DELAY_US * `RFS_CLK_MHZ) < 1 ? 1 : (`RFS_TON_DELAY_US * `RFS_CLK_MHZ))
`define RFS_RETRY_UNIT_CYCLES (`RFS_RETRY_UNIT_US * `RFS_CLK_MHZ)
`define RFS_DOWN_STEP 16'h0001

`endif

// ---- pkg/rfs_pkg.sv ----
// types shared by the regulator fault supervisor modules
// assumes nothing beyond a SystemVerilog compiler
package rfs_pkg;

  // sequencer states, gray along off-delay-ramp-on
  typedef enum logic [2:0] {
    st_off = 3'b000,
    st_delay = 3'b001,
    st_ramp = 3'b011,
    st_on = 3'b010,
    st_retry = 3'b110,
    st_latch = 3'b111,
    st_hold = 3'b101
  } rfs_state_t;

  // programmed limits arriving from the configuration store
  typedef struct packed {
    logic [15:0] vin_uv_fault;
    logic [15:0] vin_uv_warn;
    logic [15:0] vin_ov_fault;
    logic [15:0] vin_ov_warn;
    logic [15:0] vout_ov_fault;
    logic [15:0] vout_uv_fault;
    logic [15:0] pg_on;
    logic [15:0] vout_target;
  } rfs_limits_t;

  // one bit per supervised fault source
  typedef struct packed {
    logic vin_uv;
    logic vin_ov;
    logic vout_ov;
    logic vout_uv;
  } rfs_fault_t;

  typedef struct packed {
    logic s1;
    logic s2;
  } rfs_sync_t;

  typedef struct packed {
    logic active;
    logic down;
    logic [31:0] cnt;
    logic [15:0] start;
    logic [15:0] target;
    logic [15:0] ref_v;
    logic switching;
    logic done;
  } rfs_ramp_t;

  typedef struct packed {
    rfs_state_t state;
    logic en_prev;
    logic dis_seen;
    rfs_fault_t cause;
    logic pend;
    logic [31:0] cnt;
    logic [15:0] prebias;
    logic regulate;
    logic pg;
    logic [15:0] duty;
    logic ramp_go;
    logic ramp_down;
    logic [7:0] vout_ov_resp;
    logic [15:0] vout_ov_warn;
    logic [7:0] vout_uv_resp;
    logic [7:0] vin_ov_resp;
    logic [7:0] vin_uv_resp;
    logic [15:0] rdata;
    logic sense_up;
    logic [1:0] sense_range;
  } rfs_core_t;

endpackage

// ---- core/rfs_sync.sv ----
// two-flop synchroniser for one asynchronous level
// assumes the input may change at any time relative to mclk
`timescale 1ns/1ns
`default_nettype none
module rfs_sync (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // level in and synchronised level out
  input wire logic din,
  output logic dout
);

  rfs_pkg::rfs_sync_t r;
  rfs_pkg::rfs_sync_t next_r;

  // first stage feeds only the second stage
  always_comb begin
    next_r.s1 = din;
    next_r.s2 = r.s1;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign dout = r.s2;

endmodule // rfs_sync
`default_nettype wire

// ---- core/rfs_ramp.sv ----
// output reference ramp for soft start, prebias aware
// assumes go is a one-cycle pulse and stop holds the ramp idle
`timescale 1ns/1ns
`default_nettype none
`include "rfs_regs.svh"
module rfs_ramp #(
  parameter int RISE_CYCLES = `RFS_RISE_CYCLES
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // control from the sequencer
  input wire logic go,
  input wire logic down,
  input wire logic stop,
  input wire logic [15:0] start,
  input wire logic [15:0] target,
  // reference, switching request and completion
  output logic [15:0] ref_v,
  output logic switching,
  output logic done
);

  generate
    if (RISE_CYCLES < 1) begin : g_bad_rise
      $error("rfs_ramp: RISE_CYCLES must be at least 1");
    end
  endgenerate

  rfs_pkg::rfs_ramp_t r;
  rfs_pkg::rfs_ramp_t next_r;

  // point on the full-scale line from zero to target at cycle c
  function automatic logic [15:0] line_at(input logic [15:0] t, input logic [31:0] c);
    logic [47:0] p;
    p = ({32'h0, t} * {16'h0, c}) / 48'(RISE_CYCLES);
    return p[15:0];
  endfunction

  // upward ramp follows the line but never dips below the prebias, so it
  // meets the target exactly RISE_CYCLES after go whatever the start
  always_comb begin
    next_r = r;
    if (stop) begin
      next_r = '0;
    end else if (go) begin
      next_r.active = 1'b1;
      next_r.down = down;
      next_r.cnt = 32'h0;
      next_r.start = start;
      next_r.target = target;
      next_r.ref_v = start;
      next_r.switching = ~down;
      next_r.done = 1'b0;
    end else if (r.active && !r.down) begin
      next_r.cnt = r.cnt + 32'h1;
      if (line_at(r.target, next_r.cnt) > r.start) begin
        next_r.ref_v = line_at(r.target, next_r.cnt);
      end
      if (next_r.cnt >= 32'(RISE_CYCLES)) begin
        next_r.ref_v = r.target;
        next_r.active = 1'b0;
        next_r.done = 1'b1;
      end
    end else if (r.active) begin
      // above target: stay idle through the rise time, then step down
      if (!r.switching) begin
        next_r.cnt = r.cnt + 32'h1;
        if (next_r.cnt >= 32'(RISE_CYCLES)) begin
          next_r.switching = 1'b1;
        end
      end else if (r.ref_v <= r.target + `RFS_DOWN_STEP) begin
        next_r.ref_v = r.target;
        next_r.active = 1'b0;
        next_r.done = 1'b1;
      end else begin
        next_r.ref_v = r.ref_v - `RFS_DOWN_STEP;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign ref_v = r.ref_v;
  assign switching = r.switching;
  assign done = r.done;

endmodule // rfs_ramp
`default_nettype wire

// ---- test/rfs_checker_assertions.sv ----
// assertions on the supervisor top ports
// assumes a bind from the bench; one clock, async active-high reset
`timescale 1ns/1ns
`default_nettype none
module rfs_checker #(
  parameter int RISE_CYCLES = 20
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // inputs watched
  input wire logic enable_pin,
  input wire logic [15:0] vin_meas,
  input wire logic [15:0] output_sense_input,
  input wire rfs_pkg::rfs_limits_t limits,
  input wire logic [2:0] current_sense_setup,
  // outputs watched
  input wire logic [1:0] isense_range,
  input wire logic regulate_en,
  input wire logic output_good_flag,
  input wire rfs_pkg::rfs_fault_t fault_cause,
  input wire rfs_pkg::rfs_state_t seq_state
);
  // ramp window: rise time plus the sequencer hand-off slack
  localparam int RLO = RISE_CYCLES - 1;
  localparam int RHI = RISE_CYCLES + 4;
  default clocking dc @(posedge mclk);
  endclocking
  default disable iff (rst);

  vin_uv_off_a: assert property (
    vin_meas < limits.vin_uv_fault |-> ##[1:2] !regulate_en)
    else $error("regulation kept on low input");
  ov_detect_a: assert property (
    seq_state == rfs_pkg::st_on && output_sense_input > limits.vout_ov_fault
    |-> ##[1:2] fault_cause.vout_ov) else $error("output overvoltage missed");
  ov_order_a: assert property (
    $rose(fault_cause.vout_ov) |-> !output_good_flag ##1 !regulate_en)
    else $error("good flag not dropped before shutdown");
  uv_mask_a: assert property (
    $rose(fault_cause.vout_uv) |-> $past(output_good_flag))
    else $error("undervoltage flagged before good");
  latch_hold_a: assert property (
    seq_state == rfs_pkg::st_latch |-> !regulate_en ##1
    seq_state inside {rfs_pkg::st_latch, rfs_pkg::st_delay}) else $error("latch left");
  retry_dwell_a: assert property (
    $rose(seq_state == rfs_pkg::st_retry) |-> (seq_state == rfs_pkg::st_retry)[*4])
    else $error("retry delay cut short");
  retry_recover_a: assert property (
    seq_state == rfs_pkg::st_retry ##1 seq_state == rfs_pkg::st_delay |->
    (!$past(fault_cause.vin_uv) || vin_meas > limits.vin_uv_warn) &&
    (!$past(fault_cause.vin_ov) || vin_meas < limits.vin_ov_warn)) else $error("early restart");
  ramp_time_a: assert property (
    $rose(seq_state == rfs_pkg::st_ramp) && output_sense_input < limits.vout_target
    |-> ##[RLO:RHI] seq_state == rfs_pkg::st_on) else $error("rise time wrong");
  hold_off_a: assert property (
    seq_state == rfs_pkg::st_hold |-> !regulate_en && !output_good_flag)
    else $error("switching while held off");
  enable_edge_a: assert property (
    seq_state == rfs_pkg::st_off && $rose(enable_pin) |-> ##[1:5]
    seq_state == rfs_pkg::st_delay) else $error("enable edge ignored");
  range_sel_a: assert property (
    current_sense_setup[2:1] != 2'h3 |=> isense_range == $past(current_sense_setup[2:1]))
    else $error("sense range not taken");

  // main scenarios reached
  cover property (seq_state == rfs_pkg::st_latch);
  cover property ($rose(seq_state == rfs_pkg::st_retry));
  cover property (seq_state == rfs_pkg::st_hold);
endmodule // rfs_checker
`default_nettype wire

// ---- test/rfs_plant.sv ----
// model of converters and modulator around the supervisor
// assumes the bench sets input level, prebias and forced output value
`timescale 1ns/1ns
`default_nettype none
module rfs_plant (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // from the supervisor
  input wire logic regulate_en,
  input wire logic [15:0] vout_ref,
  // bench controls
  input wire logic [15:0] vin_set,
  input wire logic [15:0] pre_v,
  input wire logic ovr_en,
  input wire logic [15:0] ovr_v,
  // measurements
  output logic [15:0] vin_meas,
  output logic [15:0] vout_meas
);
  // one sample per clock; an idle stage leaves the external prebias, a
  // forced value models a rail shorted or overdriven from outside
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      vin_meas <= 16'h0000;
      vout_meas <= 16'h0000;
    end else begin
      vin_meas <= vin_set;
      vout_meas <= ovr_en ? ovr_v : (regulate_en ? vout_ref : pre_v);
    end
  end
endmodule // rfs_plant
`default_nettype wire

// ---- test/tb.sv ----
// self-checking bench of the fault supervisor with the plant model
// assumes rfs_pkg, design, plant and checker compiled before
`timescale 1ns/1ns
`default_nettype none
`include "rfs_regs.svh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin err_count++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
  localparam int RISE = 20;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic enable_pin = 1'b0;
  logic cfg_wr = 1'b0;
  logic cfg_rd = 1'b0;
  logic [7:0] cfg_code = 8'h00;
  logic [15:0] cfg_wdata = 16'h0000;
  logic [2:0] current_sense_setup = 3'h0;
  logic [15:0] vin_set = 16'h0bb8;
  logic [15:0] pre_v = 16'h0000;
  logic ovr_en = 1'b0;
  logic [15:0] ovr_v = 16'h0000;
  logic [31:0] lfsr = 32'hd810b1c5;
  logic [7:0] rc [4] = '{8'h41, 8'h45, 8'h56, 8'h5a};
  int err_count = 0;
  int compares = 0;
  rfs_pkg::rfs_limits_t limits;
  rfs_pkg::rfs_fault_t fault_cause;
  rfs_pkg::rfs_state_t seq_state;
  logic [15:0] vin_meas, output_sense_input, cfg_rdata, duty_init, vout_ref;
  logic isense_slope_up, regulate_en, output_good_flag;
  logic [1:0] isense_range;

  // uv fault kept under good threshold and warn, as a host must
  assign limits = '{16'h03e8, 16'h044c, 16'h1388, 16'h12c0, 16'h0bb8, 16'h05dc,
    16'h0708, 16'h07d0};
  always #20 mclk = ~mclk;

  rfs_supervisor #(.RISE_CYCLES(RISE), .TON_DELAY_CYCLES(1), .RETRY_UNIT_CYCLES(5)) dut_u (
    .mclk, .rst, .enable_pin, .vin_meas, .output_sense_input, .limits, .cfg_wr, .cfg_rd,
    .cfg_code, .cfg_wdata, .cfg_rdata, .current_sense_setup, .isense_slope_up,
    .isense_range, .regulate_en, .duty_init, .vout_ref, .output_good_flag, .fault_cause,
    .seq_state);
  rfs_plant plant_u (.mclk, .rst, .regulate_en, .vout_ref, .vin_set, .pre_v, .ovr_en,
    .ovr_v, .vin_meas, .vout_meas(output_sense_input));

  function automatic logic [31:0] nxt(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  // inputs always move 2 ns after the edge
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #2;
  endtask
  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    cfg_wr = 1'b1;
    cfg_code = c;
    cfg_wdata = d;
    cyc(1);
    cfg_wr = 1'b0;
    // an edge passes before the strobe may rise again
    cyc(1);
  endtask
  task automatic rd(input logic [7:0] c, input logic [15:0] e);
    cfg_rd = 1'b1;
    cfg_code = c;
    cyc(1);
    cfg_rd = 1'b0;
    cyc(1);
    `CHK(cfg_rdata, e)
  endtask
  task automatic wst(input rfs_pkg::rfs_state_t s, input int lim);
    int n;
    n = 0;
    while (seq_state !== s && n < lim) begin
      cyc(1);
      n++;
    end
    `CHK(seq_state, s)
  endtask
  // the pin acts on edges, so each change gets time to pass the synchroniser
  task automatic en(input logic v);
    enable_pin = v;
    cyc(6);
  endtask
  task automatic retry_case(input logic [7:0] c, input logic [7:0] rv, input logic side,
      input logic [15:0] bad, input logic [15:0] mid, input logic [3:0] cause);
    wr(c, {8'h00, rv});
    ovr_v = bad;
    ovr_en = side;
    if (!side) vin_set = bad;
    wst(rfs_pkg::st_retry, 20);
    `CHK(fault_cause, cause)
    `CHK(regulate_en, 1'b0)
    ovr_v = mid;
    if (mid != 16'h0000) begin
      if (!side) vin_set = mid;
      cyc(80);
      `CHK(seq_state, rfs_pkg::st_retry)
    end
    ovr_en = 1'b0;
    vin_set = 16'h0bb8;
    wst(rfs_pkg::st_on, 400);
    `CHK(fault_cause, 4'b0000)
  endtask
  task automatic end_sim;
    if (err_count == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // a full run needs about a thousand cycles; this bounds a hang
  initial begin
    repeat (20000) @(posedge mclk);
    err_count++;
    end_sim();
  end

  initial begin
    logic [15:0] d0;
    logic [1:0] rng;
    cyc(20);
    rst = 1'b0;
    `CHK(seq_state, rfs_pkg::st_off)
    rd(`RFS_OFS_VOUT_OV_WARN, `RFS_WARN_RESET);
    rd(8'h7e, 16'h0000);
    foreach (rc[i]) rd(rc[i], 16'h0000);
    foreach (rc[i]) begin
      lfsr = nxt(lfsr);
      wr(rc[i], lfsr[15:0]);
      rd(rc[i], {8'h00, lfsr[7:0]});
    end
    foreach (rc[i]) wr(rc[i], `RFS_RESP_RESET);
    wr(`RFS_OFS_VOUT_OV_WARN, 16'h09c4);
    rd(`RFS_OFS_VOUT_OV_WARN, 16'h09c4);
    en(1'b1);
    wst(rfs_pkg::st_on, 200);
    `CHK(vout_ref, 16'h07d0)
    // output-good follows one edge after the state reaches on
    cyc(1);
    `CHK(output_good_flag, 1'b1)
    // output overvoltage with latching response
    ovr_v = 16'h0c1c;
    ovr_en = 1'b1;
    wst(rfs_pkg::st_latch, 20);
    `CHK(fault_cause, 4'b0010)
    ovr_en = 1'b0;
    cyc(30);
    `CHK(seq_state, rfs_pkg::st_latch)
    en(1'b0);
    en(1'b1);
    wst(rfs_pkg::st_on, 200);
    retry_case(`RFS_OFS_VIN_UV_RESP, 8'h40, 1'b0, 16'h0384, 16'h041a, 4'b1000);
    retry_case(`RFS_OFS_VIN_OV_RESP, 8'h41, 1'b0, 16'h13ec, 16'h1324, 4'b0100);
    retry_case(`RFS_OFS_VOUT_UV_RESP, 8'h42, 1'b1, 16'h03e8, 16'h0000, 4'b0001);
    retry_case(`RFS_OFS_VOUT_OV_RESP, 8'h40, 1'b1, 16'h0c1c, 16'h0a28, 4'b0010);
    // prebias below target, at two input levels
    en(1'b0);
    pre_v = 16'h03e8;
    en(1'b1);
    wst(rfs_pkg::st_ramp, 20);
    d0 = duty_init;
    // one third of the input as a 0.16 fraction
    `CHK(d0, 16'h5555)
    wst(rfs_pkg::st_on, 200);
    en(1'b0);
    vin_set = 16'h1194;
    en(1'b1);
    wst(rfs_pkg::st_ramp, 20);
    `CHK(duty_init < d0, 1'b1)
    wst(rfs_pkg::st_on, 200);
    // prebias above target, then above the warning limit
    en(1'b0);
    vin_set = 16'h0bb8;
    pre_v = 16'h0898;
    en(1'b1);
    wst(rfs_pkg::st_on, 700);
    `CHK(vout_ref, 16'h07d0)
    en(1'b0);
    pre_v = 16'h0a8c;
    en(1'b1);
    wst(rfs_pkg::st_hold, 20);
    cyc(40);
    `CHK(seq_state, rfs_pkg::st_hold)
    pre_v = 16'h0000;
    en(1'b0);
    en(1'b1);
    wst(rfs_pkg::st_on, 200);
    // every slope and range code; the unused range code keeps the last one
    rng = 2'h0;
    for (int i = 0; i < 8; i++) begin
      current_sense_setup = i[2:0];
      if (i[2:1] != 2'h3) rng = i[2:1];
      cyc(2);
      `CHK(isense_slope_up, i[0])
      `CHK(isense_range, rng)
    end
    end_sim();
  end
endmodule // tb

bind rfs_supervisor rfs_checker #(.RISE_CYCLES(RISE_CYCLES)) chk_u (.mclk, .rst,
  .enable_pin, .vin_meas, .output_sense_input, .limits, .current_sense_setup,
  .isense_range, .regulate_en, .output_good_flag, .fault_cause, .seq_state);
`default_nettype wire
